// [logic/scr_pkg.sv]
package scr_pkg;
    // ****************************************
    // Register select codes
    // ****************************************
    localparam logic [2:0] SEL_FREQ = 3'h0;
    localparam logic [2:0] SEL_PRESCALE = 3'h1;
    localparam logic [2:0] SEL_REFCP = 3'h2;
    localparam logic [2:0] SEL_CLKDIV = 3'h3;
    localparam int SEL_LSB = 0;
    localparam int WORD_W = 32;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // ****************************************
    // Prescaler, phase and modulus word
    // ****************************************
    localparam int P_PHASE_ADJ = 28;
    localparam int P_PRESCALER = 27;
    localparam int P_PHASE_LSB = 15;
    localparam int P_MOD_LSB = 3;

    // ****************************************
    // Reference and charge pump word
    // ****************************************
    localparam int R_NOISE_LSB = 29;
    localparam int R_MUX_LSB = 26;
    localparam int R_DOUBLER = 25;
    localparam int R_HALVER = 24;
    localparam int R_RDIV_LSB = 14;
    localparam int R_DBUF = 13;
    localparam int R_CP_LSB = 9;
    localparam int R_LDF = 8;
    localparam int R_LDP = 7;
    localparam int R_POL = 6;
    localparam int R_PD = 5;
    localparam int R_CP3 = 4;
    localparam int R_CRST = 3;
    localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;

    // ****************************************
    // Clock divider and band word
    // ****************************************
    localparam int C_BAND_FAST = 23;
    localparam int C_BACKLASH = 22;
    localparam int C_CHG_CANCEL = 21;
    localparam int C_CSR = 18;
    localparam int C_MODE_LSB = 15;
    localparam int C_VAL_LSB = 3;
    localparam logic [1:0] CDIV_OFF = 2'h0;
    localparam logic [1:0] CDIV_FASTLOCK = 2'h1;
    localparam logic [1:0] CDIV_RESYNC = 2'h2;

    // ****************************************
    // Lock detect cycle counts
    // ****************************************
    localparam logic [5:0] LOCK_CNT_FRACTIONAL_NUMERATOR = 6'h28;
    localparam logic [5:0] LOCK_CNT_INT = 6'h05;
endpackage

// [logic/scr_ref_div.sv]
`timescale 1ns/1ps
// Reference divider: one output tick every ratio input ticks
module scr_ref_div (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Control
    input wire logic HOLD,
    input wire logic [9:0] RATIO,
    // Ticks
    input wire logic TICK_IN,
    output logic TICK_OUT
);
    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
    } scr_div_t;

    scr_div_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (HOLD) begin
            // Load state: counting restarts cleanly on release
            s_next.cnt = 10'h000;
        end else if (TICK_IN) begin
            // A ratio of zero behaves as one
            if (s_reg.cnt + 10'h001 >= RATIO) begin
                s_next.cnt = 10'h000;
                s_next.tick = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign TICK_OUT = s_reg.tick;
endmodule // scr_ref_div

// [logic/scr_lock_det.sv]
`timescale 1ns/1ps
// Digital lock detect: counts consecutive in-window detector cycles
module scr_lock_det (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Control
    input wire logic CLEAR,
    input wire logic [5:0] NEED,
    // Detector cycle
    input wire logic SAMPLE,
    input wire logic IN_WINDOW,
    output logic LOCKED
);
    typedef struct packed {
        logic [5:0] cnt;
        logic locked;
    } scr_lock_t;

    scr_lock_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (CLEAR) begin
            s_next = '0;
        end else if (SAMPLE) begin
            if (!IN_WINDOW) begin
                s_next = '0;
            end else if (s_reg.cnt + 6'h01 >= NEED) begin
                s_next.cnt = NEED;
                s_next.locked = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign LOCKED = s_reg.locked;
endmodule // scr_lock_det

// [logic/scr_ctrl.sv]
`timescale 1ns/1ps
module scr_ctrl
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Serial programming pins
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic SER_LOAD,
    // Reference and detector window pins
    input wire logic REFERENCE_INPUT,
    input wire logic PHASE_ERR_LT6NS,
    input wire logic PHASE_ERR_LT10NS,
    // Prescaler, phase and modulus
    output logic PRESCALER_SELECT,
    output logic PHASE_ADJUST,
    output logic [11:0] PHASE_WORD,
    output logic [11:0] FRACTIONAL_MODULUS,
    output logic PHASE_WORD_OK,
    // Reference and charge pump
    output logic DITHER_EN,
    output logic [2:0] TEST_MUX_OUTPUT_SEL,
    output logic [3:0] CP_CURRENT,
    output logic PD_POLARITY,
    output logic CP_TRISTATE,
    output logic FEEDBACK_DIV_HOLD,
    output logic OSC_POWER_DOWN,
    output logic RF_OUT_DISABLE,
    output logic DOUBLE_BUFFER_EN,
    output logic REG0_UPDATE,
    // Detector reference and lock
    output logic PFD_REF_TICK,
    output logic PFD_REF_CLK,
    output logic LOCK_DETECT,
    // Clock divider and band
    output logic BAND_SEL_FAST,
    output logic BACKLASH_NARROW,
    output logic CHARGE_CANCEL,
    output logic CYCLE_SLIP_REDUCTION,
    output logic [1:0] CLK_DIV_MODE,
    output logic [11:0] CLK_DIV_VALUE,
    output logic CLK_DIV_TIMEOUT
);
    import scr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] sdat_s;
        logic [2:0] load_s;
        logic [2:0] ref_s;
        logic [1:0] win6_s;
        logic [1:0] win10_s;
        logic [31:0] shift;
        logic [31:0] word1;
        logic [31:0] word2;
        logic [31:0] word3;
        logic [31:0] act1;
        logic [31:0] act2;
        logic halver;
        logic pfd_tick;
        logic [11:0] tmo_cnt;
        logic tmo_run;
        logic tmo_done;
        logic reg0_upd;
    } scr_state_t;

    scr_state_t s_reg, s_next;

    logic held;
    logic pd;
    logic ref_tick;
    logic rdiv_tick;
    logic lock_detect_function;
    logic in_window;
    logic [5:0] lock_need;
    logic locked;

    function automatic logic rise(input logic [2:0] sync);
        rise = sync[1] & ~sync[2];
    endfunction

    function automatic logic fall(input logic [2:0] sync);
        fall = ~sync[1] & sync[2];
    endfunction

    // ****************************************
    // Shared decode
    // ****************************************
    assign pd = s_reg.word2[R_PD];
    // Power-down forces the counters to their load state as well
    assign held = s_reg.word2[R_CRST] | pd;
    assign lock_detect_function = s_reg.word2[R_LDF];
    // Doubler off: falling edges only; on: both edges count
    assign ref_tick = s_reg.act2[R_DOUBLER] ?
        (rise(s_reg.ref_s) | fall(s_reg.ref_s)) : fall(s_reg.ref_s);
    // Narrow window: fractional with bit 7 high, integer with bit 7 low
    assign in_window = (lock_detect_function ^ s_reg.word2[R_LDP]) ?
        s_reg.win6_s[1] : s_reg.win10_s[1];
    assign lock_need = lock_detect_function ? LOCK_CNT_INT : LOCK_CNT_FRACTIONAL_NUMERATOR;

    // ****************************************
    // Reference divider and lock detect
    // ****************************************
    scr_ref_div u_ref_div (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .HOLD(held),
        .RATIO(s_reg.act2[R_RDIV_LSB +: 10]),
        .TICK_IN(ref_tick),
        .TICK_OUT(rdiv_tick)
    );

    scr_lock_det u_lock_det (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .CLEAR(pd | held),
        .NEED(lock_need),
        .SAMPLE(s_reg.pfd_tick),
        .IN_WINDOW(in_window),
        .LOCKED(locked)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        // Synchronisers: only the second stage and later are read
        s_next.sclk_s = {s_reg.sclk_s[1:0], SER_CLK};
        s_next.sdat_s = {s_reg.sdat_s[0], SER_DATA};
        s_next.load_s = {s_reg.load_s[1:0], SER_LOAD};
        s_next.ref_s = {s_reg.ref_s[1:0], REFERENCE_INPUT};
        s_next.win6_s = {s_reg.win6_s[0], PHASE_ERR_LT6NS};
        s_next.win10_s = {s_reg.win10_s[0], PHASE_ERR_LT10NS};
        s_next.reg0_upd = 1'b0;
        s_next.tmo_done = 1'b0;
        s_next.pfd_tick = 1'b0;

        // Serial input stays live even in power-down
        if (rise(s_reg.sclk_s)) begin
            s_next.shift = {s_reg.shift[30:0], s_reg.sdat_s[1]};
        end

        if (rise(s_reg.load_s)) begin
            unique case (s_reg.shift[SEL_LSB +: 3])
                SEL_PRESCALE: s_next.word1 = s_reg.shift;
                SEL_REFCP: s_next.word2 = s_reg.shift;
                SEL_CLKDIV: s_next.word3 = s_reg.shift;
                SEL_FREQ: begin
                    // Buffered fields move to the active copies here
                    s_next.act1 = s_reg.word1;
                    s_next.act2 = s_reg.word2;
                    s_next.reg0_upd = 1'b1;
                end
                default: begin
                    // Words for other registers are not held here
                end
            endcase
        end

        // Divide-by-two toggle gives a 50 percent duty detector clock
        if (held) begin
            s_next.halver = 1'b0;
        end else if (rdiv_tick) begin
            if (s_reg.act2[R_HALVER]) begin
                s_next.halver = ~s_reg.halver;
                s_next.pfd_tick = ~s_reg.halver;
            end else begin
                s_next.halver = ~s_reg.halver;
                s_next.pfd_tick = 1'b1;
            end
        end

        // Timeout counter in detector cycles, armed by each register zero write
        if (s_reg.word3[C_MODE_LSB +: 2] == CDIV_OFF || held) begin
            s_next.tmo_run = 1'b0;
            s_next.tmo_cnt = 12'h000;
        end else if (s_reg.reg0_upd) begin
            s_next.tmo_run = 1'b1;
            s_next.tmo_cnt = s_reg.word3[C_VAL_LSB +: 12];
        end else if (s_reg.tmo_run && s_reg.pfd_tick) begin
            if (s_reg.tmo_cnt <= 12'h001) begin
                s_next.tmo_run = 1'b0;
                s_next.tmo_cnt = 12'h000;
                s_next.tmo_done = 1'b1;
            end else begin
                s_next.tmo_cnt = s_reg.tmo_cnt - 12'h001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s_reg <= '0;
            s_reg.word1 <= WORD_RESET;
            s_reg.word2 <= WORD_RESET;
            s_reg.word3 <= WORD_RESET;
            s_reg.act1 <= WORD_RESET;
            s_reg.act2 <= WORD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Prescaler choice and phase word limits are the host's to respect
    assign PRESCALER_SELECT = s_reg.word1[P_PRESCALER];
    assign PHASE_ADJUST = s_reg.word1[P_PHASE_ADJ];
    assign PHASE_WORD = s_reg.act1[P_PHASE_LSB +: 12];
    assign FRACTIONAL_MODULUS = s_reg.act1[P_MOD_LSB +: 12];
    // Phase step is one modulus count, so the word must stay below it
    assign PHASE_WORD_OK = s_reg.act1[P_PHASE_LSB +: 12]
        < s_reg.act1[P_MOD_LSB +: 12];

    assign DITHER_EN = s_reg.word2[R_NOISE_LSB +: 2] == NOISE_LOW_SPUR;
    assign TEST_MUX_OUTPUT_SEL = s_reg.word2[R_MUX_LSB +: 3];
    assign CP_CURRENT = s_reg.act2[R_CP_LSB +: 4];
    assign PD_POLARITY = s_reg.word2[R_POL];
    assign CP_TRISTATE = s_reg.word2[R_CP3] | pd;
    assign FEEDBACK_DIV_HOLD = held;
    assign OSC_POWER_DOWN = pd;
    assign RF_OUT_DISABLE = pd;
    assign DOUBLE_BUFFER_EN = s_reg.word2[R_DBUF];
    assign REG0_UPDATE = s_reg.reg0_upd;

    assign PFD_REF_TICK = s_reg.pfd_tick;
    assign PFD_REF_CLK = s_reg.halver;
    assign LOCK_DETECT = locked;

    assign BAND_SEL_FAST = s_reg.word3[C_BAND_FAST];
    assign BACKLASH_NARROW = s_reg.word3[C_BACKLASH];
    assign CHARGE_CANCEL = s_reg.word3[C_CHG_CANCEL];
    assign CYCLE_SLIP_REDUCTION = s_reg.word3[C_CSR];
    assign CLK_DIV_MODE = s_reg.word3[C_MODE_LSB +: 2];
    assign CLK_DIV_VALUE = s_reg.word3[C_VAL_LSB +: 12];
    assign CLK_DIV_TIMEOUT = s_reg.tmo_done;
endmodule // scr_ctrl

// [dv/scr_host.sv]
`timescale 1ns/1ps
// Host side of the three-wire programming link
module scr_host (
    // Clock
    input wire logic CLK,
    // Serial pins
    output logic SER_CLK,
    output logic SER_DATA,
    output logic SER_LOAD
);
    initial begin
        SER_CLK = 1'b0;
        SER_DATA = 1'b0;
        SER_LOAD = 1'b0;
    end
    // Four periods a phase: clock and load are sampled through a three-flop path, data through two flops
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(negedge CLK);
            SER_DATA = w[i];
            repeat (4) @(negedge CLK);
            SER_CLK = 1'b1;
            repeat (4) @(negedge CLK);
            SER_CLK = 1'b0;
        end
        repeat (4) @(negedge CLK);
        SER_DATA = ~w[0];
        SER_LOAD = 1'b1;
        repeat (4) @(negedge CLK);
        SER_LOAD = 1'b0;
        repeat (4) @(negedge CLK);
    endtask
endmodule // scr_host

// [dv/scr_ctrl_chk.sv]
`timescale 1ns/1ps
module scr_ctrl_chk
    import scr_pkg::*;
(
    // Clock, reset and load strobe
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SER_LOAD,
    // Watched outputs
    input wire logic [11:0] PHASE_WORD,
    input wire logic [11:0] FRACTIONAL_MODULUS,
    input wire logic PHASE_WORD_OK,
    input wire logic [2:0] TEST_MUX_OUTPUT_SEL,
    input wire logic [3:0] CP_CURRENT,
    input wire logic CP_TRISTATE,
    input wire logic FEEDBACK_DIV_HOLD,
    input wire logic OSC_POWER_DOWN,
    input wire logic REG0_UPDATE,
    input wire logic PFD_REF_TICK,
    input wire logic LOCK_DETECT,
    input wire logic [1:0] CLK_DIV_MODE,
    input wire logic CLK_DIV_TIMEOUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_pd_fx;
        OSC_POWER_DOWN |-> CP_TRISTATE && FEEDBACK_DIV_HOLD;
    endproperty
    a_pd_fx: assert property (p_pd_fx) else $error("power-down left pump or dividers on");
    property p_pd_lock;
        OSC_POWER_DOWN && $past(OSC_POWER_DOWN) |-> !LOCK_DETECT;
    endproperty
    a_pd_lock: assert property (p_pd_lock) else $error("lock held in power-down");
    property p_hold;
        FEEDBACK_DIV_HOLD && $past(FEEDBACK_DIV_HOLD, 4) |-> !PFD_REF_TICK;
    endproperty
    a_hold: assert property (p_hold) else $error("tick while dividers held");
    property p_pok;
        $stable(PHASE_WORD) && $stable(FRACTIONAL_MODULUS)
            |-> PHASE_WORD_OK == (PHASE_WORD < FRACTIONAL_MODULUS);
    endproperty
    a_pok: assert property (p_pok) else $error("phase flag wrong");
    property p_mux;
        $changed(TEST_MUX_OUTPUT_SEL) |-> $past(SER_LOAD, 3) || $past(SER_LOAD, 2);
    endproperty
    a_mux: assert property (p_mux) else $error("mux select moved without load");
    property p_r0;
        REG0_UPDATE |-> ($past(SER_LOAD, 3) || $past(SER_LOAD, 2)) ##1 !REG0_UPDATE;
    endproperty
    a_r0: assert property (p_r0) else $error("bad zero-word pulse");
    property p_cp;
        $changed(CP_CURRENT) |-> REG0_UPDATE || $past(REG0_UPDATE);
    endproperty
    a_cp: assert property (p_cp) else $error("pump current not double buffered");
    property p_to;
        CLK_DIV_TIMEOUT |-> CLK_DIV_MODE != CDIV_OFF ##1 !CLK_DIV_TIMEOUT;
    endproperty
    a_to: assert property (p_to) else $error("timeout pulse wrong");
endmodule // scr_ctrl_chk

bind scr_ctrl scr_ctrl_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .SER_LOAD(SER_LOAD),
    .PHASE_WORD(PHASE_WORD), .FRACTIONAL_MODULUS(FRACTIONAL_MODULUS),
    .PHASE_WORD_OK(PHASE_WORD_OK), .TEST_MUX_OUTPUT_SEL(TEST_MUX_OUTPUT_SEL),
    .CP_CURRENT(CP_CURRENT), .CP_TRISTATE(CP_TRISTATE), .FEEDBACK_DIV_HOLD(FEEDBACK_DIV_HOLD),
    .OSC_POWER_DOWN(OSC_POWER_DOWN), .REG0_UPDATE(REG0_UPDATE), .PFD_REF_TICK(PFD_REF_TICK),
    .LOCK_DETECT(LOCK_DETECT), .CLK_DIV_MODE(CLK_DIV_MODE), .CLK_DIV_TIMEOUT(CLK_DIV_TIMEOUT));

// [dv/synth_control_regs_one_to_three_test.sv]
`timescale 1ns/1ps
module synth_control_regs_one_to_three_test;
    import scr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_in = 1'b0;
    logic lt6 = 1'b0;
    logic lt10 = 1'b0;
    logic sck, sdi, sld, psel, padj, pok, dith, pol, tri3, hold, opd, rfd, dbuf, r0u, tick;
    logic lock, bfast, bnar, ccan, cycle_slip_reduction, cto, d, h, pclk;
    int nr0 = 0;
    logic [11:0] ph, md, cval, m12, p12;
    logic [11:0] emd = 12'h000;
    logic [3:0] cp;
    logic [3:0] ecp = 4'h0;
    logic [2:0] mux;
    logic [1:0] cmode;
    logic [31:0] w;
    int nt, nto;
    int n_fail = 0;
    int compares = 0;

    scr_host u_host (.CLK(clk), .SER_CLK(sck), .SER_DATA(sdi), .SER_LOAD(sld));
    scr_ctrl u_dut (.CLK(clk), .RESET_N(rst_n), .SER_CLK(sck), .SER_DATA(sdi), .SER_LOAD(sld),
        .REFERENCE_INPUT(ref_in), .PHASE_ERR_LT6NS(lt6), .PHASE_ERR_LT10NS(lt10),
        .PRESCALER_SELECT(psel), .PHASE_ADJUST(padj), .PHASE_WORD(ph), .FRACTIONAL_MODULUS(md),
        .PHASE_WORD_OK(pok), .DITHER_EN(dith), .TEST_MUX_OUTPUT_SEL(mux), .CP_CURRENT(cp),
        .PD_POLARITY(pol), .CP_TRISTATE(tri3), .FEEDBACK_DIV_HOLD(hold), .OSC_POWER_DOWN(opd),
        .RF_OUT_DISABLE(rfd), .DOUBLE_BUFFER_EN(dbuf), .REG0_UPDATE(r0u), .PFD_REF_TICK(tick),
        .PFD_REF_CLK(pclk), .LOCK_DETECT(lock), .BAND_SEL_FAST(bfast), .BACKLASH_NARROW(bnar),
        .CHARGE_CANCEL(ccan), .CYCLE_SLIP_REDUCTION(cycle_slip_reduction), .CLK_DIV_MODE(cmode),
        .CLK_DIV_VALUE(cval), .CLK_DIV_TIMEOUT(cto));

    always #50 clk = ~clk;
    // Zero-word pulses, counted where the output has settled
    always @(negedge clk) begin
        nr0 += r0u;
    end
    // Reference runs free at one sixteenth of the clock
    always begin
        repeat (8) @(negedge clk);
        ref_in <= ~ref_in;
    end

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic run(input int n);
        nt = 0;
        nto = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            nt += tick;
            nto += cto;
        end
    endtask
    task automatic chk_w3(input logic [31:0] v);
        chk({bfast, bnar, ccan, cycle_slip_reduction}, {v[23:21], v[18]});
        chk({cmode, cval}, v[16:3]);
    endtask
    // Ticks in 960 cycles: 60 falling reference edges, divider ratio 3
    function automatic int exp_ticks(input logic dd, input logic hh);
        return 60 * (1 + dd) / (3 * (1 + hh));
    endfunction

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(46));
        repeat (19) @(negedge clk);
        chk({cp, mux, dith, opd, lock, psel, cmode}, 32'h0);
        @(negedge clk);
        rst_n = 1'b1;
        for (int m = 0; m < 4; m++) begin
            w = $urandom;
            w[30:29] = m[1:0];
            w[2:0] = SEL_REFCP;
            u_host.send_word(w);
            chk(dith, w[30:29] == NOISE_LOW_SPUR);
            chk(mux, w[28:26]);
            chk(pol, w[6]);
            chk(tri3, w[4] | w[5]);
            chk(hold, w[3] | w[5]);
            chk({opd, rfd}, {2{w[5]}});
            chk(dbuf, w[13]);
            chk(cp, ecp);
            u_host.send_word($urandom & 32'hffff_fff8);
            ecp = w[12:9];
            chk(cp, ecp);
        end
        chk(nr0, 4);
        for (int k = 0; k < 3; k++) begin
            w = $urandom;
            m12 = 12'($urandom_range(4095, 2));
            p12 = (k == 0) ? 12'h001 : (k == 1) ? m12 : m12 - 12'h001;
            w[26:15] = p12;
            w[14:3] = m12;
            w[2:0] = SEL_PRESCALE;
            u_host.send_word(w);
            chk({padj, psel}, w[28:27]);
            chk(md, emd);
            u_host.send_word($urandom & 32'hffff_fff8);
            emd = m12;
            chk({ph, md}, {p12, m12});
            chk(pok, p12 < m12);
        end
        for (int k = 0; k < 3; k++) begin
            w = $urandom;
            w[16:15] = k[1:0];
            w[2:0] = SEL_CLKDIV;
            u_host.send_word(w);
            chk_w3(w);
            u_host.send_word({~w[31:3], 3'h4 + k[2:0]});
            chk_w3(w);
        end
        lt6 = 1'b1;
        u_host.send_word({15'h0, CDIV_FASTLOCK, 12'h003, SEL_CLKDIV});
        for (int c = 0; c < 3; c++) begin
            d = (c == 1);
            h = (c == 2);
            u_host.send_word({6'h0, d, h, 10'h003, 5'h00, 1'b1, 5'h00, SEL_REFCP});
            u_host.send_word(32'h0);
            run(960);
            chk(nt >= exp_ticks(d, h) - 1 && nt <= exp_ticks(d, h) + 1, 1);
            chk(nto, 1);
            chk(lock, 1);
        end
        // Precision bit flips the window to the wide input, which is out of window
        u_host.send_word({6'h0, 2'h0, 10'h003, 5'h00, 2'h3, 4'h0, SEL_REFCP});
        run(300);
        chk(lock, 0);
        u_host.send_word({6'h0, 2'h0, 10'h003, 5'h00, 2'h2, 4'h4, SEL_REFCP});
        run(300);
        chk({lock, opd, pclk}, 3'h2);
        chk(nt, 0);
        // Fractional detect with the narrow window needs 40 samples, not 5
        u_host.send_word({6'h0, 2'h2, 10'h003, 5'h00, 2'h1, 4'h0, SEL_REFCP});
        u_host.send_word(32'h0);
        run(600);
        chk(lock, 0);
        run(600);
        chk(lock, 1);
        complete_run();
    end
endmodule // synth_control_regs_one_to_three_test
